// *** src/sgs_setpoint_group_select.sv ***
/*
 setpoint group select: four stored local setpoints, active group choice
 by register or by internal contacts, display permissions, ramp time base
 and self-tuning supervision, all behind an axi4-lite register slave.
 assumes contacts arrive asynchronously; ramp value, ramp flag and key edit
 flag come from logic on the same clock.
*/
// The address map and the AXI4-Lite slave port are this design's own decisions.
// Operation
// - end self-tuning on change to fixed pid, or on ready or manual mode
// - flash tuning led while tuning runs; off when tuning ends with new constants
// - refuse tuning start while integral or derivative time is zero
// - default pid constants are 5.0 % band, 120 s integral, 30 s derivative
// - aborted tuning leaves stored pid constants unchanged
// - setpoint group count ranges 1 to 4, resets to 1
// - four local setpoints, each clamped to sp limits, each resets to zero
// - active group number ranges 1 to group count, resets to 1
// - group number shown only with count at least 2 and display bit 2 set
// - direct group edits only when shown and no contact selects groups
// - contact codes 0 none, 1 2 3 give weights 1 2 4 when on
// - contact-driven group is one plus sum of weights of contacts on, held at group count
// - group count 1 ignores contact selection and neither shows nor allows setting of the group
// - during ramp show ramping setpoint, except stored value during key edit
// - setpoint shown only when display bit 1 is set; local setpoint register writes are accepted whatever that bit holds
// - ramp time base 0 per second, 1 per minute, 2 per hour, reset 0
// - ramp step has one more decimal than pv; four decimals hide the point
// - only local setpoints are used; no remote setpoint path exists
`timescale 1ns/10ps
`include "sgs_consts.svh"

module sgs_setpoint_group_select
   import sgs_pkg::*;
#(
   parameter int unsigned FLASH_HALF_CYCLES = `SGS_FLASH_HALF_MS * `SGS_CLK_KHZ
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire sgs_axi_in_t axi_in,
   output sgs_axi_out_t axi_out,
   input wire logic [2:0] contact_in,
   input wire logic [15:0] ramp_setpoint,
   input wire logic ramp_active,
   input wire logic key_edit_active,
   output sgs_view_t view
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] clamp_sp(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if ($signed(r) < $signed(lo))
      begin
         r = lo;
      end
      if ($signed(r) > $signed(hi))
      begin
         r = hi;
      end
      return r;
   endfunction

   function automatic logic [2:0] clamp_group(input logic [3:0] g,
                                              input logic [2:0] cnt);
      logic [2:0] r;
      r = g[2:0];
      if (g == 4'h0)
      begin
         r = 3'h1;
      end
      else if (g > {1'b0, cnt})
      begin
         r = cnt;
      end
      return r;
   endfunction

   function automatic logic [3:0] contact_weight(input logic [4:0] fn,
                                                 input logic on);
      logic [3:0] r;
      r = 4'h0;
      if (on)
      begin
         unique case (fn)
            `SGS_FN_WEIGHT1: r = 4'h1;
            `SGS_FN_WEIGHT2: r = 4'h2;
            `SGS_FN_WEIGHT4: r = 4'h4;
            default: r = 4'h0;
         endcase
      end
      return r;
   endfunction

   sgs_state_t q;
   sgs_state_t d;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic [31:0] wv;
      logic [31:0] rv;
      logic [1:0] resp;
      logic any_assigned;
      logic [3:0] wsum;
      logic [2:0] count;
      logic tune_start;
      logic tune_done;
      logic [2:0] gidx;
      wv = '0;
      rv = '0;
      resp = `SGS_RESP_OKAY;
      any_assigned = 1'b0;
      wsum = 4'h0;
      count = 3'h0;
      tune_start = 1'b0;
      tune_done = 1'b0;
      gidx = 3'h0;
      d = q;

      // contacts pass two flops; only the second is read below
      d.contact_meta = contact_in;
      d.contact_sync = q.contact_meta;

      // ---- write channel ----
      if (axi_in.awvalid && q.bus.awready)
      begin
         d.aw_held = 1'b1;
         d.awaddr = axi_in.awaddr;
      end
      if (axi_in.wvalid && q.bus.wready)
      begin
         d.w_held = 1'b1;
         d.wdata = axi_in.wdata;
         d.wstrb = axi_in.wstrb;
      end
      if (q.bus.bvalid && axi_in.bready)
      begin
         d.bus.bvalid = 1'b0;
      end
      if (q.aw_held && q.w_held && !q.bus.bvalid)
      begin
         d.aw_held = 1'b0;
         d.w_held = 1'b0;
         d.bus.bvalid = 1'b1;
         unique case (q.awaddr)
            `SGS_ADDR_CTRL:
            begin
               wv = merge_bytes({24'h0, q.pv_dec, q.view.ramp_time_base, q.auto_mode,
                                 q.run_mode, q.method}, q.wdata, q.wstrb);
               d.method = wv[`SGS_CTRL_METHOD_LSB +: 2];
               d.run_mode = wv[`SGS_CTRL_RUN_BIT];
               d.auto_mode = wv[`SGS_CTRL_AUTO_BIT];
               if (wv[`SGS_CTRL_RAMP_LSB +: 2] != 2'h3)
               begin
                  d.view.ramp_time_base = wv[`SGS_CTRL_RAMP_LSB +: 2];
               end
               d.pv_dec = wv[`SGS_CTRL_PVDEC_LSB +: 2];
            end
            `SGS_ADDR_SETUP:
            begin
               wv = merge_bytes({16'h0, q.value_display_setup, 5'h0, q.group_count},
                                q.wdata, q.wstrb);
               d.group_count = clamp_group({1'b0, wv[`SGS_SETUP_COUNT_LSB +: 3]},
                                           `SGS_MAX_GROUPS);
               d.value_display_setup = wv[`SGS_SETUP_VDS_LSB +: 8];
            end
            `SGS_ADDR_CONTACT:
            begin
               wv = merge_bytes({11'h0, q.contact_fn[2], 3'h0, q.contact_fn[1], 3'h0,
                                 q.contact_fn[0]}, q.wdata, q.wstrb);
               for (int i = 0; i < 3; i++)
               begin
                  d.contact_fn[i] = wv[i*`SGS_CONTACT_STRIDE +: 5];
               end
            end
            `SGS_ADDR_GROUP:
            begin
               if (q.view.group_edit_ok)
               begin
                  d.view.active_group = clamp_group(q.wdata[3:0], q.group_count);
               end
            end
            `SGS_ADDR_LSP0, `SGS_ADDR_LSP1, `SGS_ADDR_LSP2, `SGS_ADDR_LSP3:
            begin
               gidx = {1'b0, q.awaddr[3:2]};
               wv = merge_bytes({16'h0, q.local_setpoint[gidx[1:0]]}, q.wdata, q.wstrb);
               d.local_setpoint[gidx[1:0]] = clamp_sp(wv[15:0], q.sp_lo, q.sp_hi);
            end
            `SGS_ADDR_SP_LIMIT:
            begin
               wv = merge_bytes({q.sp_hi, q.sp_lo}, q.wdata, q.wstrb);
               d.sp_lo = wv[15:0];
               d.sp_hi = wv[31:16];
            end
            `SGS_ADDR_PID_P: d.pid_p = 16'(merge_bytes({16'h0, q.pid_p}, q.wdata, q.wstrb));
            `SGS_ADDR_PID_I: d.pid_i = 16'(merge_bytes({16'h0, q.pid_i}, q.wdata, q.wstrb));
            `SGS_ADDR_PID_D: d.pid_d = 16'(merge_bytes({16'h0, q.pid_d}, q.wdata, q.wstrb));
            `SGS_ADDR_TUNE_P: d.new_p = 16'(merge_bytes({16'h0, q.new_p}, q.wdata, q.wstrb));
            `SGS_ADDR_TUNE_I: d.new_i = 16'(merge_bytes({16'h0, q.new_i}, q.wdata, q.wstrb));
            `SGS_ADDR_TUNE_D: d.new_d = 16'(merge_bytes({16'h0, q.new_d}, q.wdata, q.wstrb));
            `SGS_ADDR_TUNE:
            begin
               tune_start = q.wdata[`SGS_TUNE_START_BIT] && q.wstrb[0];
               tune_done = q.wdata[`SGS_TUNE_DONE_BIT] && q.wstrb[0];
            end
            `SGS_ADDR_STATUS: resp = `SGS_RESP_OKAY;
            default: resp = `SGS_RESP_SLVERR;
         endcase
         d.bus.bresp = resp;
      end
      d.bus.awready = !d.aw_held && !d.bus.bvalid;
      d.bus.wready = !d.w_held && !d.bus.bvalid;

      // ---- self-tuning supervision ----
      unique case (q.tune)
         SGS_TS_IDLE:
         begin
            // no start with a zero integral or derivative time
            if (tune_start && q.method == SGS_CM_SELF_TUNING && q.run_mode && q.auto_mode
                && q.pid_i != 16'h0 && q.pid_d != 16'h0)
            begin
               d.tune = SGS_TS_RUN;
            end
         end
         SGS_TS_RUN:
         begin
            if (d.method == SGS_CM_FIXED_PID || !d.run_mode || !d.auto_mode)
            begin
               d.tune = SGS_TS_IDLE;
            end
            else if (tune_done)
            begin
               // constants only move on a clean finish; an abort keeps old ones, a reset loads the defaults
               d.pid_p = q.new_p;
               d.pid_i = q.new_i;
               d.pid_d = q.new_d;
               d.tune = SGS_TS_IDLE;
            end
         end
      endcase
      if (d.tune == SGS_TS_RUN)
      begin
         if (q.flash_cnt >= FLASH_HALF_CYCLES - 1)
         begin
            d.flash_cnt = '0;
            d.view.tuning_led = !q.view.tuning_led;
         end
         else
         begin
            d.flash_cnt = q.flash_cnt + 32'h1;
         end
      end
      else
      begin
         d.flash_cnt = '0;
         d.view.tuning_led = 1'b0;
      end
      d.view.self_tuning = (d.tune == SGS_TS_RUN);

      // ---- group selection ----
      for (int i = 0; i < 3; i++)
      begin
         if (d.contact_fn[i] == `SGS_FN_WEIGHT1 || d.contact_fn[i] == `SGS_FN_WEIGHT2
             || d.contact_fn[i] == `SGS_FN_WEIGHT4)
         begin
            any_assigned = 1'b1;
         end
         wsum = wsum + contact_weight(d.contact_fn[i], q.contact_sync[i]);
      end
      count = d.group_count;
      if (count >= 3'h2 && any_assigned)
      begin
         d.view.active_group = clamp_group(wsum + 4'h1, count);
      end
      else
      begin
         d.view.active_group = clamp_group({1'b0, d.view.active_group}, count);
      end
      d.view.show_group = count >= 3'h2 && d.value_display_setup[`SGS_VDS_GROUP_BIT];
      d.view.group_edit_ok = d.view.show_group && !any_assigned;
      d.view.show_setpoint = d.value_display_setup[`SGS_VDS_SP_BIT];

      // ---- setpoint routing; only stored local values exist ----
      gidx = d.view.active_group - 3'h1;
      d.view.target_sp = d.local_setpoint[gidx[1:0]];
      d.view.display_sp = (ramp_active && !key_edit_active) ? ramp_setpoint
                          : d.local_setpoint[gidx[1:0]];
      d.view.ramp_decimals = {1'b0, d.pv_dec} + 3'h1;
      d.view.ramp_dp_on = d.pv_dec != 2'h3;

      // ---- read channel ----
      if (q.bus.rvalid && axi_in.rready)
      begin
         d.bus.rvalid = 1'b0;
      end
      if (axi_in.arvalid && q.bus.arready)
      begin
         resp = `SGS_RESP_OKAY;
         unique case (axi_in.araddr)
            `SGS_ADDR_CTRL: rv = {24'h0, q.pv_dec, q.view.ramp_time_base, q.auto_mode,
                                  q.run_mode, q.method};
            `SGS_ADDR_SETUP: rv = {16'h0, q.value_display_setup, 5'h0, q.group_count};
            `SGS_ADDR_CONTACT: rv = {11'h0, q.contact_fn[2], 3'h0, q.contact_fn[1], 3'h0,
                                     q.contact_fn[0]};
            `SGS_ADDR_GROUP: rv = {29'h0, q.view.active_group};
            `SGS_ADDR_LSP0: rv = {16'h0, q.local_setpoint[0]};
            `SGS_ADDR_LSP1: rv = {16'h0, q.local_setpoint[1]};
            `SGS_ADDR_LSP2: rv = {16'h0, q.local_setpoint[2]};
            `SGS_ADDR_LSP3: rv = {16'h0, q.local_setpoint[3]};
            `SGS_ADDR_SP_LIMIT: rv = {q.sp_hi, q.sp_lo};
            `SGS_ADDR_PID_P: rv = {16'h0, q.pid_p};
            `SGS_ADDR_PID_I: rv = {16'h0, q.pid_i};
            `SGS_ADDR_PID_D: rv = {16'h0, q.pid_d};
            `SGS_ADDR_TUNE: rv = {30'h0, q.view.tuning_led, q.view.self_tuning};
            `SGS_ADDR_TUNE_P: rv = {16'h0, q.new_p};
            `SGS_ADDR_TUNE_I: rv = {16'h0, q.new_i};
            `SGS_ADDR_TUNE_D: rv = {16'h0, q.new_d};
            `SGS_ADDR_STATUS: rv = {q.view.display_sp, 5'h0, q.contact_sync, q.view.ramp_dp_on,
                                    q.view.group_edit_ok, q.view.show_group,
                                    q.view.show_setpoint, q.view.active_group, q.view.self_tuning};
            default: resp = `SGS_RESP_SLVERR;
         endcase
         d.bus.rvalid = 1'b1;
         d.bus.rdata = rv;
         d.bus.rresp = resp;
      end
      d.bus.arready = !d.bus.rvalid;

      // ---- synchronous reset ----
      if (!resetn)
      begin
         d = '0;
         d.bus.awready = 1'b1;
         d.bus.wready = 1'b1;
         d.bus.arready = 1'b1;
         d.group_count = `SGS_RST_GROUP_COUNT;
         d.view.active_group = `SGS_RST_GROUP;
         d.view.ramp_time_base = `SGS_RST_RAMP_BASE;
         d.view.ramp_decimals = 3'h1;
         d.view.ramp_dp_on = 1'b1;
         d.local_setpoint = {4{`SGS_RST_LSP}};
         d.sp_lo = `SGS_RST_SP_LO;
         d.sp_hi = `SGS_RST_SP_HI;
         d.pid_p = `SGS_RST_PID_P;
         d.pid_i = `SGS_RST_PID_I;
         d.pid_d = `SGS_RST_PID_D;
         d.tune = SGS_TS_IDLE;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      q <= d;
   end

   assign axi_out = q.bus;
   assign view = q.view;

endmodule

// *** common/sgs_consts.svh ***
/*
 constants of the setpoint group select block: register byte offsets,
 field positions, reset values and timing figures.
 assumes it is included by bare name after the package is compiled.
*/
`ifndef SGS_CONSTS_SVH
`define SGS_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SGS_ADDR_CTRL 8'h00
`define SGS_ADDR_SETUP 8'h04
`define SGS_ADDR_CONTACT 8'h08
`define SGS_ADDR_GROUP 8'h0c
`define SGS_ADDR_LSP0 8'h10
`define SGS_ADDR_LSP1 8'h14
`define SGS_ADDR_LSP2 8'h18
`define SGS_ADDR_LSP3 8'h1c
`define SGS_ADDR_SP_LIMIT 8'h20
`define SGS_ADDR_PID_P 8'h24
`define SGS_ADDR_PID_I 8'h28
`define SGS_ADDR_PID_D 8'h2c
`define SGS_ADDR_TUNE 8'h30
`define SGS_ADDR_TUNE_P 8'h34
`define SGS_ADDR_TUNE_I 8'h38
`define SGS_ADDR_TUNE_D 8'h3c
`define SGS_ADDR_STATUS 8'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define SGS_CTRL_METHOD_LSB 0
`define SGS_CTRL_RUN_BIT 2
`define SGS_CTRL_AUTO_BIT 3
`define SGS_CTRL_RAMP_LSB 4
`define SGS_CTRL_PVDEC_LSB 6
`define SGS_SETUP_COUNT_LSB 0
`define SGS_SETUP_VDS_LSB 8
`define SGS_VDS_SP_BIT 1
`define SGS_VDS_GROUP_BIT 2
`define SGS_CONTACT_STRIDE 8
`define SGS_TUNE_START_BIT 0
`define SGS_TUNE_DONE_BIT 1

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define SGS_RST_PID_P 16'h0032
`define SGS_RST_PID_I 16'h0078
`define SGS_RST_PID_D 16'h001e
`define SGS_RST_GROUP_COUNT 3'h1
`define SGS_RST_GROUP 3'h1
`define SGS_RST_LSP 16'h0000
`define SGS_RST_RAMP_BASE 2'h0
`define SGS_RST_SP_LO 16'h8000
`define SGS_RST_SP_HI 16'h7fff
`define SGS_FN_WEIGHT1 5'h01
`define SGS_FN_WEIGHT2 5'h02
`define SGS_FN_WEIGHT4 5'h03
`define SGS_MAX_GROUPS 3'h4
`define SGS_RESP_OKAY 2'h0
`define SGS_RESP_SLVERR 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define SGS_FLASH_HALF_MS 250
`define SGS_CLK_KHZ 200000

`endif

// *** common/sgs_pkg.sv ***
/*
 types of the setpoint group select block: bus carriers, modes, state.
 assumes a single 200 MHz clock domain.
*/
package sgs_pkg;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } sgs_axi_in_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sgs_axi_out_t;

   typedef enum logic [1:0] {
      SGS_CM_ONOFF = 2'h0,
      SGS_CM_FIXED_PID = 2'h1,
      SGS_CM_SELF_TUNING = 2'h2
   } sgs_method_t;

   typedef enum logic {
      SGS_TS_IDLE = 1'b0,
      SGS_TS_RUN = 1'b1
   } sgs_tune_t;

   typedef struct packed {
      logic [15:0] target_sp;
      logic [15:0] display_sp;
      logic show_setpoint;
      logic show_group;
      logic group_edit_ok;
      logic [2:0] active_group;
      logic self_tuning;
      logic tuning_led;
      logic [1:0] ramp_time_base;
      logic [2:0] ramp_decimals;
      logic ramp_dp_on;
   } sgs_view_t;

   typedef struct packed {
      sgs_axi_out_t bus;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] method;
      logic run_mode;
      logic auto_mode;
      logic [1:0] pv_dec;
      logic [2:0] group_count;
      logic [7:0] value_display_setup;
      logic [2:0][4:0] contact_fn;
      logic [3:0][15:0] local_setpoint;
      logic [15:0] sp_lo;
      logic [15:0] sp_hi;
      logic [15:0] pid_p;
      logic [15:0] pid_i;
      logic [15:0] pid_d;
      logic [15:0] new_p;
      logic [15:0] new_i;
      logic [15:0] new_d;
      sgs_tune_t tune;
      logic [31:0] flash_cnt;
      logic [2:0] contact_meta;
      logic [2:0] contact_sync;
      sgs_view_t view;
   } sgs_state_t;

endpackage

// *** sim/sgs_setpoint_group_select_sva.sv ***
/*
 checker on the top ports of the setpoint group select.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module sgs_setpoint_group_select_sva
   import sgs_pkg::*;
#(
   parameter int unsigned FLASH_HALF_CYCLES = 4
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire sgs_axi_in_t axi_in,
   input wire sgs_axi_out_t axi_out,
   input wire logic [2:0] contact_in,
   input wire logic [15:0] ramp_setpoint,
   input wire logic ramp_active,
   input wire logic key_edit_active,
   input wire sgs_view_t view
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic led_q;
   logic [31:0] led_cnt_q;
   // cycles the led has held one level while tuning runs
   always_ff @(posedge clk)
   begin
      led_q <= view.tuning_led;
      if (!resetn || !view.self_tuning || view.tuning_led != led_q)
         led_cnt_q <= '0;
      else
         led_cnt_q <= led_cnt_q + 32'h1;
   end
   sequence s_ramp_shown;
      (ramp_active && !key_edit_active && $stable(ramp_setpoint)) [*3];
   endsequence
   sequence s_edit_held;
      (key_edit_active && $stable(view.target_sp)) [*3];
   endsequence
   a_group_range: assert property (view.active_group >= 3'h1 && view.active_group <= 3'h4)
      else $error("active group out of range");
   a_led_off: assert property (!view.self_tuning [*2] |-> !view.tuning_led)
      else $error("led lit without tuning");
   a_led_flash: assert property (led_cnt_q <= FLASH_HALF_CYCLES - 1)
      else $error("led stopped flashing");
   a_display_ramp: assert property (s_ramp_shown |-> view.display_sp == ramp_setpoint)
      else $error("ramp value not shown");
   a_display_edit: assert property (s_edit_held |-> view.display_sp == view.target_sp)
      else $error("stored value not shown during edit");
   a_dp_decimals: assert property (view.ramp_dp_on == (view.ramp_decimals != 3'h4))
      else $error("ramp point and decimals disagree");
   a_base_legal: assert property (view.ramp_time_base != 2'h3)
      else $error("illegal ramp time base");
   a_edit_shown: assert property (view.group_edit_ok |-> view.show_group)
      else $error("group editable while hidden");
   a_read_answer: assert property (axi_in.arvalid && axi_out.arready |=> axi_out.rvalid)
      else $error("read not answered");
   a_write_answer: assert property (axi_in.awvalid && axi_out.awready && axi_in.wvalid && axi_out.wready
      |-> ##[1:2] axi_out.bvalid)
      else $error("write not answered");
endmodule
bind sgs_setpoint_group_select sgs_setpoint_group_select_sva #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) sva_inst
(
   .clk(clk),
   .resetn(resetn),
   .axi_in(axi_in),
   .axi_out(axi_out),
   .contact_in(contact_in),
   .ramp_setpoint(ramp_setpoint),
   .ramp_active(ramp_active),
   .key_edit_active(key_edit_active),
   .view(view)
);

// *** sim/sgs_keypad_model.sv ***
/*
 keypad and contact model: internal contacts, ramp value, ramp and edit flags.
 assumes drive is called just after a rising clock edge.
*/
`timescale 1ns/10ps
module sgs_keypad_model
(
   input wire logic clk,
   output logic [2:0] contact_in,
   output logic [15:0] ramp_setpoint,
   output logic ramp_active,
   output logic key_edit_active
);
   logic [15:0] idle_q = 16'h0000;
   logic [15:0] ramp_q = 16'h0000;
   initial
   begin
      contact_in = 3'h0;
      ramp_active = 1'b0;
      key_edit_active = 1'b0;
   end
   // no ramp running means no valid value, so the line keeps changing
   always @(posedge clk)
      idle_q <= ~idle_q;
   assign ramp_setpoint = ramp_active ? ramp_q : idle_q;
   task automatic drive(input logic [2:0] c, input logic ra, input logic ke, input logic [15:0] rs);
      contact_in <= c;
      ramp_active <= ra;
      key_edit_active <= ke;
      ramp_q <= rs;
   endtask
endmodule

// *** sim/sgs_setpoint_group_select_bench.sv ***
/*
 bench: register tests over axi4-lite, contacts and ramp through the keypad model.
 assumes the design answers every request; each wait is bounded.
*/
`timescale 1ns/10ps
`include "sgs_consts.svh"
module sgs_setpoint_group_select_bench
   import sgs_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   sgs_axi_in_t ain = '0;
   sgs_axi_out_t aout;
   logic [2:0] contact_in;
   logic [15:0] ramp_setpoint;
   logic ramp_active;
   logic key_edit_active;
   sgs_view_t view;
   int failures = 0;
   int compares = 0;
   logic [15:0] lsp_w [4] = '{16'h0010, 16'hff80, 16'h7000, 16'h8000};
   logic [15:0] lsp_e [4] = '{16'h0010, 16'hff80, 16'h0100, 16'hff00};
   logic [31:0] abort_ctrl [3] = '{32'h0000000d, 32'h0000000a, 32'h00000006};
   always #2.5 clk = ~clk;
   sgs_setpoint_group_select #(.FLASH_HALF_CYCLES(4)) sgs_setpoint_group_select_inst
   (
      .clk(clk),
      .resetn(resetn),
      .axi_in(ain),
      .axi_out(aout),
      .contact_in(contact_in),
      .ramp_setpoint(ramp_setpoint),
      .ramp_active(ramp_active),
      .key_edit_active(key_edit_active),
      .view(view)
   );
   sgs_keypad_model sgs_keypad_model_inst
   (
      .clk(clk),
      .contact_in(contact_in),
      .ramp_setpoint(ramp_setpoint),
      .ramp_active(ramp_active),
      .key_edit_active(key_edit_active)
   );
   task automatic conclude();
      $display("compares %0d, failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
         failures++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      ain.awvalid <= 1'b1;
      ain.awaddr <= a;
      ain.wvalid <= 1'b1;
      ain.wdata <= d;
      ain.wstrb <= 4'hf;
      ain.bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (aout.awready)
            ain.awvalid <= 1'b0;
         if (aout.wready)
            ain.wvalid <= 1'b0;
         if (aout.bvalid)
            break;
      end
      if (n == 40)
      begin
         failures++;
         conclude();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      ain.arvalid <= 1'b1;
      ain.araddr <= a;
      ain.rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (aout.arready)
            ain.arvalid <= 1'b0;
         if (aout.rvalid)
            break;
      end
      if (n == 40)
      begin
         failures++;
         conclude();
      end
      chk(aout.rdata & m, e);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(`SGS_ADDR_PID_P, 32'hffffffff, 32'h00000032);
      rd(`SGS_ADDR_PID_I, 32'hffffffff, 32'h00000078);
      rd(`SGS_ADDR_PID_D, 32'hffffffff, 32'h0000001e);
      rd(`SGS_ADDR_SETUP, 32'h7, 32'h1);
      rd(`SGS_ADDR_GROUP, 32'h7, 32'h1);
      rd(`SGS_ADDR_CTRL, 32'h30, 32'h0);
      for (int i = 0; i < 4; i++)
         rd(`SGS_ADDR_LSP0 + 8'(4 * i), 32'hffff, 32'h0);
      rd(8'h44, 32'hffffffff, 32'h0);
      wr(8'h44, 32'h1);
      chk({28'h0, aout.bresp, aout.rresp}, 32'ha);
      $display("test reset values finished");
      for (int i = 0; i < 3; i++)
      begin
         wr(`SGS_ADDR_CTRL, 32'he);
         wr(`SGS_ADDR_TUNE, 32'h1);
         rd(`SGS_ADDR_TUNE, 32'h1, 32'h1);
         repeat (12) @(posedge clk);
         wr(`SGS_ADDR_CTRL, abort_ctrl[i]);
         rd(`SGS_ADDR_TUNE, 32'h3, 32'h0);
         rd(`SGS_ADDR_PID_P, 32'hffff, 32'h32);
      end
      wr(`SGS_ADDR_CTRL, 32'he);
      wr(`SGS_ADDR_TUNE, 32'h1);
      for (int i = 0; i < 3; i++)
         wr(`SGS_ADDR_TUNE_P + 8'(4 * i), 32'h40 + 32'(i));
      wr(`SGS_ADDR_TUNE, 32'h2);
      rd(`SGS_ADDR_TUNE, 32'h3, 32'h0);
      for (int i = 0; i < 3; i++)
         rd(`SGS_ADDR_PID_P + 8'(4 * i), 32'hffff, 32'h40 + 32'(i));
      for (int i = 0; i < 2; i++)
      begin
         wr(`SGS_ADDR_PID_I, (i == 0) ? 32'h0 : 32'h5);
         wr(`SGS_ADDR_PID_D, (i == 0) ? 32'h5 : 32'h0);
         wr(`SGS_ADDR_TUNE, 32'h1);
         rd(`SGS_ADDR_TUNE, 32'h1, 32'h0);
      end
      $display("test tuning finished");
      wr(`SGS_ADDR_SP_LIMIT, 32'h0100ff00);
      for (int i = 0; i < 4; i++)
         wr(`SGS_ADDR_LSP0 + 8'(4 * i), {16'h0, lsp_w[i]});
      for (int i = 0; i < 4; i++)
         rd(`SGS_ADDR_LSP0 + 8'(4 * i), 32'hffff, {16'h0, lsp_e[i]});
      wr(`SGS_ADDR_SETUP, 32'h604);
      for (int g = 1; g <= 4; g++)
      begin
         wr(`SGS_ADDR_GROUP, 32'(g));
         repeat (4) @(posedge clk);
         chk({29'h0, view.active_group}, 32'(g));
         chk({16'h0, view.target_sp}, {16'h0, lsp_e[g - 1]});
      end
      chk({29'h0, view.show_setpoint, view.show_group, view.group_edit_ok}, 32'h7);
      wr(`SGS_ADDR_CONTACT, 32'h00030201);
      for (int p = 0; p < 4; p++)
      begin
         sgs_keypad_model_inst.drive(3'(p), 1'b0, 1'b0, 16'h0);
         repeat (6) @(posedge clk);
         chk({29'h0, view.active_group}, 32'(p + 1));
      end
      chk({31'h0, view.group_edit_ok}, 32'h0);
      // weight four alone overshoots four groups and is held at the count
      wr(`SGS_ADDR_CONTACT, 32'h3);
      sgs_keypad_model_inst.drive(3'h1, 1'b0, 1'b0, 16'h0);
      wr(`SGS_ADDR_GROUP, 32'h1);
      repeat (6) @(posedge clk);
      chk({29'h0, view.active_group}, 32'h4);
      wr(`SGS_ADDR_SETUP, 32'h601);
      repeat (6) @(posedge clk);
      chk({29'h0, view.active_group}, 32'h1);
      chk({29'h0, view.show_setpoint, view.show_group, view.group_edit_ok}, 32'h4);
      wr(`SGS_ADDR_SETUP, 32'h004);
      sgs_keypad_model_inst.drive(3'h0, 1'b1, 1'b0, 16'h1234);
      repeat (6) @(posedge clk);
      chk({29'h0, view.show_setpoint, view.show_group, view.group_edit_ok}, 32'h0);
      chk({16'h0, view.display_sp}, 32'h1234);
      sgs_keypad_model_inst.drive(3'h0, 1'b1, 1'b1, 16'h1234);
      repeat (4) @(posedge clk);
      chk({16'h0, view.display_sp}, {16'h0, lsp_e[0]});
      $display("test groups and display finished");
      for (int i = 0; i < 4; i++)
      begin
         wr(`SGS_ADDR_CTRL, 32'((i << 6) | ((i % 3) << 4)));
         repeat (4) @(posedge clk);
         chk({30'h0, view.ramp_time_base}, 32'(i % 3));
         chk({28'h0, view.ramp_decimals, view.ramp_dp_on}, 32'(((i + 1) << 1) | (i != 3)));
      end
      $display("test ramp format finished");
      conclude();
   end
endmodule
